/* logic/prdt_pkg.sv */
// Constants, code-groups and types shared by the receive decode and 10 Mb/s datapath.
package prdt_pkg;

  // ==========================================
  // Clocking
  localparam int CLK_MHZ = 100;
  localparam int NIB_CLK_100_KHZ = 25000;
  localparam int NIB_CLK_10_KHZ = 2500;
  localparam logic [5:0] HALF_100 = 6'(CLK_MHZ * 1000 / (2 * NIB_CLK_100_KHZ));
  localparam logic [5:0] HALF_10 = 6'(CLK_MHZ * 1000 / (2 * NIB_CLK_10_KHZ));

  // ==========================================
  // Descrambler
  localparam int IDLE_WINDOW_US = 40;
  localparam logic [11:0] IDLE_WINDOW_CYC = 12'(IDLE_WINDOW_US * CLK_MHZ);
  localparam logic [3:0] IDLE_RUN_BITS = 4'hA;
  localparam logic [3:0] KEY_LEN = 4'hB;
  localparam int KEY_TAP_HI = 10;
  localparam int KEY_TAP_LO = 8;

  // ==========================================
  // Code-groups and fixed nibbles
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [3:0] NIB_SSD = 4'h5;
  localparam logic [3:0] NIB_BAD_SSD = 4'hE;
  localparam logic [3:0] NIB_ERR = 4'h0;

  // ==========================================
  // 10 Mb/s timing
  localparam int MAN_HALF_NS = 50;
  localparam logic [3:0] MAN_HALF_CYC = 4'(MAN_HALF_NS * CLK_MHZ / 1000);
  localparam logic [3:0] MAN_BIT_CYC = 4'(2 * MAN_HALF_NS * CLK_MHZ / 1000);
  localparam logic [3:0] MID_GAP_CYC = 4'(3 * MAN_HALF_NS * CLK_MHZ / 2000);
  localparam logic [3:0] MAN_LATE_CYC = 4'(13 * MAN_HALF_NS * CLK_MHZ / 5000);
  localparam int EOF_GAP_NS = 200;
  localparam logic [4:0] EOF_GAP_CYC = 5'(EOF_GAP_NS * CLK_MHZ / 1000);
  localparam int NLP_WIDTH_NS = 100;
  localparam logic [3:0] NLP_WIDTH_CYC = 4'(NLP_WIDTH_NS * CLK_MHZ / 1000);
  localparam int NLP_PERIOD_MS = 16;
  localparam int NLP_PERIOD_CYC = NLP_PERIOD_MS * CLK_MHZ * 1000;
  localparam int JABBER_MS = 45;
  localparam int JABBER_CYC = JABBER_MS * CLK_MHZ * 1000;
  localparam int LINK_LOSS_MS = 150;
  localparam int LINK_LOSS_CYC = LINK_LOSS_MS * CLK_MHZ * 1000;
  localparam int SQE_DELAY_NS = 1000;
  localparam int SQE_WIDTH_NS = 1000;
  localparam logic [7:0] SQE_START_CYC = 8'(SQE_DELAY_NS * CLK_MHZ / 1000);
  localparam logic [7:0] SQE_END_CYC = 8'((SQE_DELAY_NS + SQE_WIDTH_NS) * CLK_MHZ / 1000);

  // ==========================================
  // Types
  typedef enum logic [1:0] {AL_HUNT, AL_GOTJ, AL_FRAME} prdt_align_e;

  // Returns {valid, nibble} for a data code-group.
  function automatic logic [4:0] prdt_dec_5b(input logic [4:0] g);
    case (g)
      5'h1E: prdt_dec_5b = 5'h10;
      5'h09: prdt_dec_5b = 5'h11;
      5'h14: prdt_dec_5b = 5'h12;
      5'h15: prdt_dec_5b = 5'h13;
      5'h0A: prdt_dec_5b = 5'h14;
      5'h0B: prdt_dec_5b = 5'h15;
      5'h0E: prdt_dec_5b = 5'h16;
      5'h0F: prdt_dec_5b = 5'h17;
      5'h12: prdt_dec_5b = 5'h18;
      5'h13: prdt_dec_5b = 5'h19;
      5'h16: prdt_dec_5b = 5'h1A;
      5'h17: prdt_dec_5b = 5'h1B;
      5'h1A: prdt_dec_5b = 5'h1C;
      5'h1B: prdt_dec_5b = 5'h1D;
      5'h1C: prdt_dec_5b = 5'h1E;
      5'h1D: prdt_dec_5b = 5'h1F;
      default: prdt_dec_5b = 5'h00;
    endcase
  endfunction : prdt_dec_5b

endpackage : prdt_pkg

/* logic/prdt_descrambler.sv */
// Self-synchronising 100 Mb/s descrambler with idle-search window.
module prdt_descrambler
  import prdt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Scrambled bits
  input wire logic scr_bit,
  input wire logic scr_valid,
  // Descrambled bits and status
  output logic plain_bit_q,
  output logic plain_valid_q,
  output logic locked_q,
  output logic abort_q
);

  logic [10:0] key_q;
  logic [3:0] fill_q;
  logic [3:0] ones_q;
  logic [11:0] win_q;

  wire key_next = key_q[KEY_TAP_HI] ^ key_q[KEY_TAP_LO];
  wire plain = scr_bit ^ key_next;
  wire idle_seen = locked_q && scr_valid && plain && (ones_q >= IDLE_RUN_BITS - 4'h1);
  wire win_end = locked_q && (win_q == IDLE_WINDOW_CYC - 12'h001);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_q <= 11'h000;
      fill_q <= 4'h0;
      ones_q <= 4'h0;
      win_q <= 12'h000;
      locked_q <= 1'b0;
      abort_q <= 1'b0;
      plain_bit_q <= 1'b0;
      plain_valid_q <= 1'b0;
    end else begin
      plain_valid_q <= scr_valid && locked_q && !win_end;
      plain_bit_q <= plain;
      abort_q <= win_end;
      if (win_end) begin
        locked_q <= 1'b0;
        fill_q <= 4'h0;
        ones_q <= 4'h0;
      end else if (scr_valid) begin
        if (locked_q) begin
          key_q <= {key_q[9:0], key_next};
          ones_q <= !plain ? 4'h0 : (ones_q == IDLE_RUN_BITS) ? ones_q : ones_q + 4'h1;
        end else begin
          key_q <= {key_q[9:0], ~scr_bit};
          fill_q <= fill_q + 4'h1;
          if (fill_q == KEY_LEN - 4'h1) begin
            locked_q <= 1'b1;
          end
        end
      end
      if (!locked_q || idle_seen || win_end) begin
        win_q <= 12'h000;
      end else begin
        win_q <= win_q + 12'h001;
      end
    end
  end

endmodule : prdt_descrambler

/* logic/prdt_ten_meg_tx.sv */
// 10 Mb/s transmit unit: serialiser, Manchester coder, link pulses, jabber and heartbeat.
module prdt_ten_meg_tx
  import prdt_pkg::*;
#(
  parameter int NLP_CYC = NLP_PERIOD_CYC,
  parameter int JAB_CYC = JABBER_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Nibble side
  input wire logic nib_rise,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  // Line and status
  output logic line_q,
  output logic drive_q,
  output logic active_q,
  output logic jabber_q,
  output logic sqe_q,
  output logic take_q,
  output logic [3:0] take_nib_q
);

  logic [3:0] sh_q;
  logic [1:0] bit_q;
  logic [3:0] cyc_q;
  logic [23:0] nlp_q;
  logic [3:0] pw_q;
  logic [22:0] jab_q;
  logic [7:0] sqe_t_q;

  wire load = nib_rise && tx_en && !jabber_q;
  wire cur = sh_q[bit_q];
  wire second = cyc_q >= MAN_HALF_CYC;
  wire nlp_fire = !active_q && !tx_en && (nlp_q == 24'(NLP_CYC - 1));
  wire tx_end = active_q && (nib_rise || jabber_q) && !load;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 4'h0;
      bit_q <= 2'h0;
      cyc_q <= 4'h0;
      active_q <= 1'b0;
      take_q <= 1'b0;
      take_nib_q <= 4'h0;
      line_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      take_q <= load;
      if (load) begin
        take_nib_q <= txd;
      end
      if (load) begin
        sh_q <= txd;
        bit_q <= 2'h0;
        cyc_q <= 4'h0;
        active_q <= 1'b1;
      end else if (tx_end) begin
        active_q <= 1'b0;
      end else if (active_q) begin
        cyc_q <= (cyc_q == MAN_BIT_CYC - 4'h1) ? 4'h0 : cyc_q + 4'h1;
        if (cyc_q == MAN_BIT_CYC - 4'h1) begin
          bit_q <= bit_q + 2'h1;
        end
      end
      line_q <= active_q ? (second ? cur : ~cur) : (pw_q != 4'h0);
      drive_q <= active_q || (pw_q != 4'h0);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nlp_q <= 24'h000000;
      pw_q <= 4'h0;
    end else begin
      nlp_q <= (active_q || tx_en || nlp_fire) ? 24'h000000 : nlp_q + 24'h000001;
      pw_q <= nlp_fire ? NLP_WIDTH_CYC : (pw_q != 4'h0) ? pw_q - 4'h1 : 4'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jab_q <= 23'h000000;
      jabber_q <= 1'b0;
    end else if (!tx_en) begin
      jab_q <= 23'h000000;
      jabber_q <= 1'b0;
    end else if (jab_q == 23'(JAB_CYC - 1)) begin
      jabber_q <= 1'b1;
    end else begin
      jab_q <= jab_q + 23'h000001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sqe_t_q <= 8'h00;
      sqe_q <= 1'b0;
    end else begin
      sqe_t_q <= tx_end ? 8'h01 : (sqe_t_q == 8'h00 || sqe_t_q == SQE_END_CYC) ? 8'h00 : sqe_t_q + 8'h01;
      sqe_q <= (sqe_t_q >= SQE_START_CYC) && (sqe_t_q < SQE_END_CYC);
    end
  end

endmodule : prdt_ten_meg_tx

/* logic/prdt_top.sv */
// Receive decode for 100 Mb/s and 10 Mb/s MII datapath of an Ethernet PHY.
// Notes on behaviour
// - During idle the descrambler learns its key, then holds it for data.
// - No idle within 40 us aborts reception and restarts synchronisation.
// - Code-group alignment is set by J/K and kept until the frame ends.
// - J/K becomes two 0101 nibbles; data groups become nibbles.
// - Receive valid rises with the first translated start-delimiter nibble.
// - T/R or two idles end carrier and valid; they give no nibbles.
// - Valid holds until T/R, two idles or link failure; nibbles follow the receive clock.
// - In a frame any group but data, idle or T/R raises the error flag.
// - A bad start delimiter gives error with nibble 1110 and no valid.
// - The 100 Mb/s receive clock runs at 25 MHz from the local reference.
// - At 10 Mb/s transmit nibbles are taken at 2.5 MHz while enable is high.
// - Half-duplex 10 Mb/s loops transmit data back without collision; heartbeat given.
// - Transmit nibbles become a 10 Mb/s Manchester stream on 20 MHz timing.
// - With transmit enable low, normal link pulses are sent.
// - Received Manchester is checked and reversed pair polarity is corrected.
// - Received Manchester is decoded into serial bits, then four-bit nibbles.
// - At 10 Mb/s receive nibbles are valid on a 2.5 MHz clock rise.
// - Link pulses seen while idle keep the 10 Mb/s link status alive.
// - Overlong transmit enable aborts transmission within 45 ms; clears when enable drops.
// - A status bit shows that jabber was detected.
// - J K T R idle codes are fixed; J only after idle, K only after J.
// - Invalid code-groups during a frame raise the error flag.
module prdt_top
  import prdt_pkg::*;
#(
  parameter int NLP_CYC = NLP_PERIOD_CYC,
  parameter int JAB_CYC = JABBER_CYC,
  parameter int LINK_CYC = LINK_LOSS_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Mode
  input wire logic speed_100,
  input wire logic full_duplex,
  // 100 Mb/s recovered scrambled bits
  input wire logic scr_bit_in,
  input wire logic scr_bit_valid,
  // 10 Mb/s squelched line level
  input wire logic rx10_line,
  // MII transmit
  input wire logic [3:0] transmit_nibble_in,
  input wire logic transmit_valid_flag,
  output logic transmit_nibble_clock,
  // MII receive
  output logic [3:0] receive_nibble_out,
  output logic receive_valid_flag,
  output logic receive_error_flag,
  output logic receive_nibble_clock,
  output logic collision_flag,
  output logic carrier_sense,
  // 10 Mb/s line drive
  output logic tx10_line,
  output logic tx10_drive,
  // Status
  input wire logic jabber_status_read,
  output logic jabber_detected,
  output logic link_ok_10,
  output logic descrambler_locked
);

  // ==========================================
  // Nibble clock divider
  logic [5:0] ph_q;
  wire [5:0] half = speed_100 ? HALF_100 : HALF_10;
  wire ph_wrap = ph_q >= (half + half - 6'h01);
  wire [5:0] ph_d = ph_wrap ? 6'h00 : ph_q + 6'h01;
  wire slot = ph_q == half - 6'h01;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= 6'h00;
      receive_nibble_clock <= 1'b0;
      transmit_nibble_clock <= 1'b0;
    end else begin
      ph_q <= ph_d;
      receive_nibble_clock <= ph_d < half;
      transmit_nibble_clock <= ph_d < half;
    end
  end

  // ==========================================
  // 100 Mb/s descramble and align
  wire plain_bit;
  wire plain_valid;
  wire abort100;
  prdt_descrambler u_descr (
    .clk(clk),
    .rst_n(rst_n),
    .scr_bit(scr_bit_in),
    .scr_valid(scr_bit_valid),
    .plain_bit_q(plain_bit),
    .plain_valid_q(plain_valid),
    .locked_q(descrambler_locked),
    .abort_q(abort100)
  );

  prdt_align_e al_q;
  logic [9:0] sh_q;
  logic [2:0] cnt5_q;
  logic prev_t_q;
  logic prev_i_q;
  logic [1:0] e100_n_q;
  logic [5:0] e100_d_q;

  wire [9:0] sh_n = {sh_q[8:0], plain_bit};
  wire [4:0] grp = sh_n[4:0];
  wire [4:0] dec = prdt_dec_5b(grp);
  wire grp_end = plain_valid && (cnt5_q == 3'h4);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      al_q <= AL_HUNT;
      sh_q <= 10'h000;
      cnt5_q <= 3'h0;
      prev_t_q <= 1'b0;
      prev_i_q <= 1'b0;
      e100_n_q <= 2'h0;
      e100_d_q <= 6'h00;
    end else begin
      e100_n_q <= 2'h0;
      if (plain_valid) begin
        sh_q <= sh_n;
        cnt5_q <= (al_q == AL_HUNT || grp_end) ? 3'h0 : cnt5_q + 3'h1;
      end
      if (abort100) begin
        al_q <= AL_HUNT;
      end else if (plain_valid) begin
        case (al_q)
          AL_HUNT: begin
            if (sh_n == {CG_IDLE, CG_J}) begin
              al_q <= AL_GOTJ;
            end
          end
          AL_GOTJ: begin
            if (grp_end && grp == CG_K) begin
              e100_n_q <= 2'h2;
              e100_d_q <= {2'b10, NIB_SSD};
              prev_t_q <= 1'b0;
              prev_i_q <= 1'b0;
              al_q <= AL_FRAME;
            end else if (grp_end) begin
              e100_n_q <= 2'h1;
              e100_d_q <= {2'b01, NIB_BAD_SSD};
              al_q <= AL_HUNT;
            end
          end
          AL_FRAME: begin
            if (grp_end) begin
              prev_t_q <= (grp == CG_T);
              prev_i_q <= (grp == CG_IDLE);
              if (prev_t_q && grp == CG_R) begin
                al_q <= AL_HUNT;
              end else if (prev_i_q && grp == CG_IDLE) begin
                al_q <= AL_HUNT;
              end else if (prev_t_q || (dec[4] == 1'b0 && grp != CG_T && grp != CG_IDLE)) begin
                e100_n_q <= 2'h1;
                e100_d_q <= {2'b11, NIB_ERR};
              end else if (dec[4]) begin
                e100_n_q <= 2'h1;
                e100_d_q <= {2'b10, dec[3:0]};
              end
            end
          end
          default: al_q <= AL_HUNT;
        endcase
      end
    end
  end

  // ==========================================
  // 10 Mb/s transmit
  wire tx_active;
  wire tx_jabber;
  wire tx_sqe;
  wire tx_take;
  wire [3:0] tx_take_nib;
  prdt_ten_meg_tx #(
    .NLP_CYC(NLP_CYC),
    .JAB_CYC(JAB_CYC)
  ) u_ten_meg_transmit_unit (
    .clk(clk),
    .rst_n(rst_n),
    .nib_rise(ph_wrap && !speed_100),
    .tx_en(transmit_valid_flag),
    .txd(transmit_nibble_in),
    .line_q(tx10_line),
    .drive_q(tx10_drive),
    .active_q(tx_active),
    .jabber_q(tx_jabber),
    .sqe_q(tx_sqe),
    .take_q(tx_take),
    .take_nib_q(tx_take_nib)
  );
  wire half_10 = !speed_100 && !full_duplex;
  wire lb_push = half_10 && tx_take;

  // ==========================================
  // 10 Mb/s receive
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic prev_q;
  logic pol_q;
  logic car_q;
  logic [4:0] gap_q;
  logic [3:0] mid_q;
  logic [3:0] nsh_q;
  logic [1:0] nb_q;
  logic [1:0] bits_q;
  logic bad_q;
  logic e10_q;
  logic [5:0] e10_d_q;
  logic [23:0] link_q;

  wire edge10 = lvl_q != prev_q;
  wire is_mid = edge10 && (!car_q || mid_q >= MID_GAP_CYC);
  wire late = car_q && (mid_q > MAN_LATE_CYC);
  wire rbit = lvl_q ^ pol_q;
  wire car_end = car_q && !edge10 && (gap_q == EOF_GAP_CYC - 5'h01);
  wire lpulse = car_end && (bits_q < 2'h2);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      s1_q <= rx10_line;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
      prev_q <= lvl_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pol_q <= 1'b0;
      car_q <= 1'b0;
      gap_q <= 5'h00;
      mid_q <= 4'h0;
      nsh_q <= 4'h0;
      nb_q <= 2'h0;
      bits_q <= 2'h0;
      bad_q <= 1'b0;
      e10_q <= 1'b0;
      e10_d_q <= 6'h00;
    end else begin
      e10_q <= 1'b0;
      gap_q <= edge10 ? 5'h00 : (gap_q == EOF_GAP_CYC) ? gap_q : gap_q + 5'h01;
      mid_q <= is_mid ? 4'h0 : (mid_q == 4'hF) ? mid_q : mid_q + 4'h1;
      if (!car_q && gap_q == EOF_GAP_CYC) begin
        pol_q <= lvl_q;
      end
      if (edge10) begin
        car_q <= 1'b1;
      end else if (car_end) begin
        car_q <= 1'b0;
        nb_q <= 2'h0;
        bits_q <= 2'h0;
        bad_q <= 1'b0;
      end
      if (is_mid) begin
        nsh_q <= {rbit, nsh_q[3:1]};
        nb_q <= nb_q + 2'h1;
        bits_q <= (bits_q == 2'h2) ? bits_q : bits_q + 2'h1;
        bad_q <= (nb_q == 2'h3) ? 1'b0 : (bad_q || late);
        if (nb_q == 2'h3 && !half_10) begin
          e10_q <= 1'b1;
          e10_d_q <= {1'b1, bad_q || late, rbit, nsh_q[3:1]};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_q <= 24'h000000;
      link_ok_10 <= 1'b0;
    end else if (lpulse || car_end) begin
      link_q <= 24'h000000;
      link_ok_10 <= 1'b1;
    end else if (link_q == 24'(LINK_CYC - 1)) begin
      link_ok_10 <= 1'b0;
    end else begin
      link_q <= link_q + 24'h000001;
    end
  end

  // ==========================================
  // Receive nibble queue and MII outputs
  logic [5:0] q_mem [0:3];
  logic [1:0] wr_q;
  logic [1:0] rd_q;
  logic [2:0] cnt_q;

  wire [1:0] push_n = speed_100 ? e100_n_q : {1'b0, e10_q || lb_push};
  wire [5:0] push_d = speed_100 ? e100_d_q : (lb_push ? {2'b10, tx_take_nib} : e10_d_q);
  wire pop = slot && (cnt_q != 3'h0);
  wire [1:0] push_ok = (cnt_q <= 3'h4 - {1'b0, push_n}) ? push_n : 2'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 2'h0;
      rd_q <= 2'h0;
      cnt_q <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        q_mem[i] <= 6'h00;
      end
    end else begin
      if (push_ok != 2'h0) begin
        q_mem[wr_q] <= push_d;
      end
      if (push_ok == 2'h2) begin
        q_mem[wr_q + 2'h1] <= push_d;
      end
      wr_q <= wr_q + push_ok;
      rd_q <= rd_q + {1'b0, pop};
      cnt_q <= cnt_q + {1'b0, push_ok} - {2'b00, pop};
    end
  end

  wire [5:0] head = q_mem[rd_q];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_valid_flag <= 1'b0;
      receive_error_flag <= 1'b0;
      receive_nibble_out <= 4'h0;
    end else if (slot) begin
      receive_valid_flag <= pop && head[5];
      receive_error_flag <= pop && head[4];
      receive_nibble_out <= pop ? head[3:0] : 4'h0;
    end
  end

  // ==========================================
  // Carrier, collision and jabber status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carrier_sense <= 1'b0;
      collision_flag <= 1'b0;
      jabber_detected <= 1'b0;
    end else begin
      carrier_sense <= speed_100 ? (al_q == AL_FRAME) : (car_q || (half_10 && tx_active));
      collision_flag <= half_10 && ((tx_active && car_q) || tx_sqe);
      jabber_detected <= tx_jabber || (jabber_detected && !jabber_status_read);
    end
  end

endmodule : prdt_top

/* sim/prdt_props.sv */
// Port checker for receive framing, nibble clocks, loopback, link pulses and jabber.
module prdt_props
  import prdt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Mode and transmit
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic transmit_valid_flag,
  input wire logic transmit_nibble_clock,
  // Receive
  input wire logic [3:0] receive_nibble_out,
  input wire logic receive_valid_flag,
  input wire logic receive_error_flag,
  input wire logic receive_nibble_clock,
  input wire logic collision_flag,
  // Line and status
  input wire logic tx10_drive,
  input wire logic jabber_status_read,
  input wire logic jabber_detected
);
  logic [5:0] hi_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Counts how long the receive clock has been high.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_q <= '0;
    end else begin
      hi_q <= receive_nibble_clock ? hi_q + 6'h01 : '0;
    end
  end
  // ==========================================
  // Assertions
  ssd_bad_a: assert property (receive_error_flag && !receive_valid_flag |-> receive_nibble_out == NIB_BAD_SSD)
    else $error("bad delimiter nibble wrong");
  rxd_slot_a: assert property ($changed(receive_nibble_out) |-> $fell(receive_nibble_clock))
    else $error("receive nibble changed off slot");
  dv_slot_a: assert property ($rose(receive_valid_flag) |-> $fell(receive_nibble_clock))
    else $error("receive valid rose off slot");
  clk_ratio_a: assert property ($fell(receive_nibble_clock) && $past(rst_n, 41)
    && speed_100 == $past(speed_100, 41) |-> hi_q == (speed_100 ? 6'h02 : 6'h14))
    else $error("receive clock high time wrong");
  clk_same_a: assert property (transmit_nibble_clock == receive_nibble_clock)
    else $error("transmit and receive clocks differ");
  no_col_a: assert property (!speed_100 && !full_duplex && receive_valid_flag |-> !collision_flag)
    else $error("collision during loopback");
  jab_stop_a: assert property ($rose(jabber_detected) |-> ##[0:12] !tx10_drive)
    else $error("jabber did not stop line");
  jab_clear_a: assert property (jabber_status_read && !transmit_valid_flag |=> !jabber_detected)
    else $error("jabber status not cleared");
  nlp_width_a: assert property ($rose(tx10_drive) && !transmit_valid_flag && !speed_100
    |-> tx10_drive[*8] ##1 tx10_drive ##1 tx10_drive ##1 !tx10_drive)
    else $error("link pulse width wrong");
  cover property ($rose(jabber_detected));
  cover property (receive_error_flag && !receive_valid_flag);
  cover property (!speed_100 && receive_valid_flag);
endmodule : prdt_props

bind prdt_top prdt_props props_u (
  .clk(clk),
  .rst_n(rst_n),
  .speed_100(speed_100),
  .full_duplex(full_duplex),
  .transmit_valid_flag(transmit_valid_flag),
  .transmit_nibble_clock(transmit_nibble_clock),
  .receive_nibble_out(receive_nibble_out),
  .receive_valid_flag(receive_valid_flag),
  .receive_error_flag(receive_error_flag),
  .receive_nibble_clock(receive_nibble_clock),
  .collision_flag(collision_flag),
  .tx10_drive(tx10_drive),
  .jabber_status_read(jabber_status_read),
  .jabber_detected(jabber_detected)
);

/* sim/prdt_mac_model.sv */
// MAC controller model on the MII: captures receive nibbles, sends transmit nibbles.
module prdt_mac_model (
  // MII receive
  input wire logic rx_clk,
  input wire logic [3:0] rxd,
  input wire logic rx_dv,
  input wire logic rx_er,
  // MII transmit
  input wire logic tx_clk,
  output logic [3:0] txd,
  output logic tx_en
);
  logic [4:0] got_q[$];
  logic [3:0] send_q[$];
  logic hold_en;
  initial begin
    txd = 4'h0;
    tx_en = 1'b0;
    hold_en = 1'b0;
  end
  always @(posedge rx_clk) begin
    if (rx_dv) begin
      got_q.push_back({rx_er, rxd});
    end
  end
  always @(posedge tx_clk) begin
    if (send_q.size() > 0) begin
      tx_en <= 1'b1;
      txd <= send_q.pop_front();
    end else begin
      tx_en <= hold_en;
      txd <= ~txd;
    end
  end
endmodule : prdt_mac_model

/* sim/tb_top.sv */
// Bench: 100 Mb/s frames, bad delimiter, 10 Mb/s loopback, link pulses and jabber.
module tb_top
  import prdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, spd, scr_bit, scr_vld, jab_rd, bad_ssd;
  logic [3:0] txd, rxd;
  logic tx_en, tx_clk, rx_dv, rx_er, rx_clk, col, drv, jab, lock, rx_ln, lnk;
  int fail_count = 0;
  int compares = 0;
  int n;
  logic [4:0] rows [16][2] = '{'{5'h1E, 5'h00}, '{5'h09, 5'h01}, '{5'h14, 5'h02}, '{5'h15, 5'h03},
    '{5'h0A, 5'h04}, '{5'h0B, 5'h05}, '{5'h0E, 5'h06}, '{5'h0F, 5'h07}, '{5'h12, 5'h08}, '{5'h13, 5'h09},
    '{5'h16, 5'h0A}, '{5'h17, 5'h0B}, '{5'h1A, 5'h0C}, '{5'h1B, 5'h0D}, '{5'h1C, 5'h0E}, '{5'h1D, 5'h0F}};
  prdt_top #(.NLP_CYC(200), .JAB_CYC(500), .LINK_CYC(2000)) dut_u (.clk(clk), .rst_n(rst_n), .speed_100(spd),
    .full_duplex(1'b0), .scr_bit_in(scr_bit), .scr_bit_valid(scr_vld), .rx10_line(rx_ln),
    .transmit_nibble_in(txd), .transmit_valid_flag(tx_en), .transmit_nibble_clock(tx_clk),
    .receive_nibble_out(rxd), .receive_valid_flag(rx_dv), .receive_error_flag(rx_er),
    .receive_nibble_clock(rx_clk), .collision_flag(col), .carrier_sense(), .tx10_line(), .tx10_drive(drv),
    .jabber_status_read(jab_rd), .jabber_detected(jab), .link_ok_10(lnk), .descrambler_locked(lock));
  prdt_mac_model mac_u (.rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .tx_clk(tx_clk),
    .txd(txd), .tx_en(tx_en));
  // ==========================================
  // Tasks
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Sends one code-group, first bit first; the unscrambled idle stream keeps the key at zero.
  task automatic grp(input logic [4:0] g);
    for (int i = 4; i >= 0; i--) begin
      @(posedge clk);
      scr_bit <= g[i];
    end
  endtask : grp
  task automatic give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  // ==========================================
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge rx_clk) begin
    if (rx_er && !rx_dv && rxd === 4'hE) begin
      bad_ssd = 1'b1;
    end
  end
  // Cuts a hang at about six times the expected run.
  initial begin
    #100us;
    fail_count++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    spd = 1'b1;
    scr_bit = 1'b1;
    scr_vld = 1'b0;
    jab_rd = 1'b0;
    rx_ln = 1'b0;
    bad_ssd = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    scr_vld <= 1'b1;
    repeat (8) grp(CG_IDLE);
    chk(5'(lock), 5'h01);
    grp(CG_J);
    grp(CG_K);
    foreach (rows[i]) grp(rows[i][0]);
    grp(5'h00);
    grp(CG_T);
    grp(CG_R);
    repeat (6) grp(CG_IDLE);
    chk(5'(mac_u.got_q.size()), 5'h13);
    repeat (2) chk(mac_u.got_q.pop_front(), {1'b0, NIB_SSD});
    foreach (rows[i]) chk(mac_u.got_q.pop_front(), rows[i][1]);
    chk(mac_u.got_q.pop_front(), 5'h10);
    $display("test frame done");
    grp(CG_J);
    grp(rows[0][0]);
    repeat (3) grp(CG_IDLE);
    grp(CG_J);
    grp(CG_K);
    grp(rows[3][0]);
    repeat (4) grp(CG_IDLE);
    chk(5'(bad_ssd), 5'h01);
    chk(5'(mac_u.got_q.size()), 5'h03);
    $display("test delimiters done");
    spd <= 1'b0;
    mac_u.got_q.delete();
    repeat (60) @(posedge clk);
    for (int i = 0; i < 8; i++) mac_u.send_q.push_back(4'(i * 3));
    for (n = 0; n < 500 && (mac_u.send_q.size() > 0 || tx_en); n++) @(posedge clk);
    for (n = 0; n < 300 && !col; n++) @(posedge clk);
    chk(5'(col), 5'h01);
    chk(5'(mac_u.got_q.size()), 5'h08);
    for (int i = 0; i < 8; i++) chk(mac_u.got_q.pop_front(), {1'b0, 4'(i * 3)});
    for (n = 0; n < 400 && !drv; n++) @(posedge clk);
    chk(5'(drv), 5'h01);
    $display("test loopback done");
    rx_ln <= 1'b1;
    repeat (10) @(posedge clk);
    rx_ln <= 1'b0;
    repeat (40) @(posedge clk);
    chk(5'(lnk), 5'h01);
    $display("test link pulse done");
    mac_u.hold_en = 1'b1;
    repeat (700) @(posedge clk);
    chk(5'({jab, drv}), 5'h02);
    mac_u.hold_en = 1'b0;
    repeat (100) @(posedge clk);
    jab_rd <= 1'b1;
    @(posedge clk);
    jab_rd <= 1'b0;
    @(posedge clk);
    chk(5'(jab), 5'h00);
    $display("test jabber done");
    rst_n <= 1'b0;
    @(posedge clk);
    chk(5'({rx_dv, rx_er, jab, drv, lock}), 5'h00);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(5'(rx_clk), 5'h01);
    $display("test reset done");
    give_verdict();
  end
endmodule : tb_top
